// ---- design/port_pkg.sv ----
// Purpose: Shared constants for the data-bus shared I/O port
// Assumes: Byte-wide register port, 16-bit address
// Notes:   Offsets are the low 16 address bits
package port_pkg;
  localparam int          DATA_W            = 8;
  localparam int          ADDR_W            = 16;
  localparam int          MODE_W            = 3;
  localparam logic [15:0] PIN_DIRECTION_OFS = 16'hfe3c;
  localparam logic [15:0] PULLUP_SELECT_OFS = 16'hfe43;
  localparam logic [15:0] OUTPUT_LATCH_OFS  = 16'hff0c;
  localparam logic [15:0] PIN_LEVEL_OFS     = 16'hffbc;
  localparam logic [7:0]  PIN_DIRECTION_RST = 8'h00;
  localparam logic [7:0]  PULLUP_SELECT_RST = 8'h00;
  localparam logic [7:0]  OUTPUT_LATCH_RST  = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
  // Value returned for the write-only direction register (undefined, arbitrary)
  localparam logic [7:0]  DIRECTION_READ    = 8'h00;
  localparam logic [2:0]  MODE_BUS_LO       = 3'h4;
  localparam logic [2:0]  MODE_BUS_HI       = 3'h6;
  localparam logic [2:0]  MODE_SINGLE_CHIP  = 3'h7;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SW_STANDBY,
    PWR_HW_STANDBY
  } power_state_e;
endpackage : port_pkg

// ---- design/pin_cell.sv ----
// Purpose: One pin's driver and pull-up steering
// Assumes: Mode decode done by the parent
// Notes:   Pure combinational
module pin_cell
  import port_pkg::*;
(
  input  wire logic bus_mode,
  input  wire logic single_mode,
  input  wire logic direction_bit,
  input  wire logic output_bit,
  input  wire logic pullup_bit,
  input  wire logic bus_out,
  input  wire logic bus_oe,
  input  wire logic hw_standby,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_on
);
  // Bus controller owns the pin in expanded modes
  always_comb begin
    if (bus_mode) begin
      pin_out = bus_out;                                   // RL3
      pin_oe  = bus_oe & ~hw_standby;                      // RL14
    end else begin
      pin_out = output_bit;                                // RL14
      pin_oe  = single_mode & direction_bit & ~hw_standby; // RL4
    end
  end

  // Pull-up only for a mode 7 input with select set
  assign pullup_on = single_mode & ~direction_bit & pullup_bit & ~hw_standby; // RL11 RL12 RL13
endmodule : pin_cell

// ---- design/readback_hold.sv ----
// Purpose: Pin-level readback value with hold in software standby
// Assumes: Pins synchronous to clk
// Notes:   Frozen copy keeps last value while standing by
module readback_hold
  import port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              sw_standby,
  input  wire logic [DATA_W-1:0] direction,
  input  wire logic [DATA_W-1:0] latch,
  input  wire logic [DATA_W-1:0] pin_in,
  output logic      [DATA_W-1:0] level
);
  logic [DATA_W-1:0] live;
  logic [DATA_W-1:0] held;

  // Output bits show the latch, input bits the pin
  assign live = (direction & latch) | (~direction & pin_in); // RL7

  // Track live value until standby freezes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= 8'h00;
    end else if (!sw_standby) begin
      held <= live;
    end
  end

  assign level = sw_standby ? held : live; // RL9
endmodule : readback_hold

// ---- design/data_bus_shared_io_port.sv ----
// Purpose: 8-bit I/O port whose pins double as external data bus lines
// Assumes: Registers reached by a byte-wide strobe port; pins synchronous
// Notes:   Bus cycles and mode selection live outside; this block decodes op_mode and steers pins
//
// Overview of operation
// RL1 - Direction register is 8-bit write-only; reads return an undefined value
// RL2 - Direction clears on power-on reset and hardware standby, kept in software standby
// RL3 - Modes 4 to 6 ignore direction; all pins become data bus lines
// RL4 - Mode 7: direction bit one drives output, zero makes input
// RL5 - Output latch is 8-bit read/write, clears on reset and hardware standby
// RL6 - Pin-level register is read-only; writes there change nothing
// RL7 - Pin-level read gives latch for output bits, pin level for inputs
// RL8 - Software writes output values to the latch, not the pin-level register
// RL9 - Readback shows pins after reset and hardware standby; holds in software standby
// RL10 - Pull-up select is 8-bit read/write, clears on reset and hardware standby
// RL11 - Pull-up on only in mode 7 for input bits with select set
// RL12 - Pull-ups off for bus pins and mode 7 outputs in every state
// RL13 - Pull-ups off after reset and in hardware standby; kept in software standby
// RL14 - Mode 7 driver from latch and direction; bus modes from bus controller
module data_bus_shared_io_port
  import port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [MODE_W-1:0] op_mode,
  input  wire logic              hw_standby,
  input  wire logic              sw_standby,
  input  wire logic [DATA_W-1:0] bus_dout,
  input  wire logic              bus_doe,
  output logic      [DATA_W-1:0] bus_din,
  input  wire logic [DATA_W-1:0] io_pin_in,
  output logic      [DATA_W-1:0] io_pin_out,
  output logic      [DATA_W-1:0] io_pin_oe,
  output logic      [DATA_W-1:0] pullup_en
);
  logic [DATA_W-1:0] pin_direction;
  logic [DATA_W-1:0] output_latch;
  logic [DATA_W-1:0] pullup_select;
  logic [DATA_W-1:0] pin_level_readback;
  logic              bus_mode;
  logic              single_mode;
  power_state_e      power_state;

  // Address match used by both write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Mode decode; other modes leave pins as plain inputs
  assign bus_mode    = (op_mode >= MODE_BUS_LO) && (op_mode <= MODE_BUS_HI); // RL3
  assign single_mode = (op_mode == MODE_SINGLE_CHIP);                        // RL4

  // Hardware standby wins over software standby
  always_comb begin
    if (hw_standby) begin
      power_state = PWR_HW_STANDBY;
    end else if (sw_standby) begin
      power_state = PWR_SW_STANDBY;
    end else begin
      power_state = PWR_RUN;
    end
  end

  // Direction register; hardware standby acts as a reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_direction <= PIN_DIRECTION_RST; // RL2
    end else begin
      case (power_state)
        PWR_HW_STANDBY: pin_direction <= PIN_DIRECTION_RST; // RL2
        PWR_SW_STANDBY: pin_direction <= pin_direction;     // RL2
        PWR_RUN: begin
          if (reg_write && hit(reg_addr, PIN_DIRECTION_OFS)) begin
            pin_direction <= reg_wdata; // RL1
          end
        end
        default: pin_direction <= PIN_DIRECTION_RST;
      endcase
    end
  end

  // Output latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_latch <= OUTPUT_LATCH_RST; // RL5
    end else begin
      case (power_state)
        PWR_HW_STANDBY: output_latch <= OUTPUT_LATCH_RST; // RL5
        PWR_SW_STANDBY: output_latch <= output_latch;     // RL5
        PWR_RUN: begin
          if (reg_write && hit(reg_addr, OUTPUT_LATCH_OFS)) begin
            output_latch <= reg_wdata; // RL5 RL8
          end
        end
        default: output_latch <= OUTPUT_LATCH_RST;
      endcase
    end
  end

  // Pull-up select; cleared in hardware standby so pull-ups start off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pullup_select <= PULLUP_SELECT_RST; // RL10
    end else begin
      case (power_state)
        PWR_HW_STANDBY: pullup_select <= PULLUP_SELECT_RST; // RL10 RL13
        PWR_SW_STANDBY: pullup_select <= pullup_select;     // RL10 RL13
        PWR_RUN: begin
          if (reg_write && hit(reg_addr, PULLUP_SELECT_OFS)) begin
            pullup_select <= reg_wdata; // RL10
          end
        end
        default: pullup_select <= PULLUP_SELECT_RST;
      endcase
    end
  end

  // Readback mux with standby hold
  readback_hold u_readback (
    .clk        (clk),
    .arst_n     (arst_n),
    .sw_standby (sw_standby & ~hw_standby),
    .direction  (pin_direction),
    .latch      (output_latch),
    .pin_in     (io_pin_in),
    .level      (pin_level_readback)
  );

  // One cell per pin
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_pin
      pin_cell u_cell (
        .bus_mode      (bus_mode),
        .single_mode   (single_mode),
        .direction_bit (pin_direction[i]),
        .output_bit    (output_latch[i]),
        .pullup_bit    (pullup_select[i]),
        .bus_out       (bus_dout[i]),
        .bus_oe        (bus_doe),
        .hw_standby    (hw_standby),
        .pin_out       (io_pin_out[i]),
        .pin_oe        (io_pin_oe[i]),
        .pullup_on     (pullup_en[i])
      );
    end
  endgenerate

  // Data bus samples the pins directly
  assign bus_din = io_pin_in;

  // Read data registered; valid the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (hit(reg_addr, PIN_DIRECTION_OFS)) begin
        reg_rdata <= DIRECTION_READ; // RL1
      end else if (hit(reg_addr, OUTPUT_LATCH_OFS)) begin
        reg_rdata <= output_latch;
      end else if (hit(reg_addr, PULLUP_SELECT_OFS)) begin
        reg_rdata <= pullup_select;
      end else if (hit(reg_addr, PIN_LEVEL_OFS)) begin
        reg_rdata <= pin_level_readback; // RL6 RL7
      end else begin
        reg_rdata <= UNMAPPED_READ;
      end
    end else begin
      reg_rdata <= 8'h00; // Zero outside the read answer cycle
    end
  end
endmodule : data_bus_shared_io_port

// ---- verif/port_chk.sv ----
// Purpose: Assertions on the shared I/O port pins and register reads
// Assumes: Sees only the top module ports
// Notes:   Bound to every instance of the port
module port_chk
  import port_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [2:0]  op_mode,
  input wire logic        hw_standby,
  input wire logic        sw_standby,
  input wire logic [7:0]  bus_dout,
  input wire logic        bus_doe,
  input wire logic [7:0]  io_pin_out,
  input wire logic [7:0]  io_pin_oe,
  input wire logic [7:0]  pullup_en
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single-chip and out of hardware standby; registers steer the pins only then
  wire logic m7 = op_mode == MODE_SINGLE_CHIP && !hw_standby;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Write-only register never leaks its contents
  a_dir_read: assert property (reg_read && reg_addr == PIN_DIRECTION_OFS |=> reg_rdata == DIRECTION_READ)
    else $error("direction read");
  a_dir_drive: assert property (reg_write && reg_addr == PIN_DIRECTION_OFS && !sw_standby && !hw_standby ##1 m7
    |-> io_pin_oe == $past(reg_wdata)) else $error("direction drive");
  a_latch_drive: assert property (reg_write && reg_addr == OUTPUT_LATCH_OFS && !sw_standby && !hw_standby ##1 m7
    |-> io_pin_out == $past(reg_wdata)) else $error("latch drive");
  a_bus_steer: assert property (op_mode >= MODE_BUS_LO && op_mode <= MODE_BUS_HI && !hw_standby
    |-> io_pin_oe == {8{bus_doe}} && io_pin_out == bus_dout) else $error("bus steering");
  a_pull_mode: assert property (pullup_en != 8'h00 |-> m7) else $error("pull-up mode");
  a_pull_output: assert property ((pullup_en & io_pin_oe) == 8'h00) else $error("pull-up on output");
  // Clear during hardware standby must show once it ends
  a_hw_clear: assert property ($fell(hw_standby) && m7 |-> io_pin_oe == 8'h00 && pullup_en == 8'h00)
    else $error("standby clear");
  a_sw_hold: assert property (sw_standby && $past(sw_standby) && m7 && $past(m7)
    |-> $stable(io_pin_oe) && $stable(pullup_en)) else $error("software standby hold");
endmodule : port_chk

bind data_bus_shared_io_port port_chk u_chk (.*);

// ---- verif/pin_partner.sv ----
// Purpose: External circuitry on the eight port pins
// Assumes: Bench picks which pins it drives
// Notes:   Floating pins wander every cycle
module pin_partner (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] noise = 8'h00;
  // Undriven, unpulled pins must not look like a stable level
  always @(posedge clk) begin
    noise <= ~noise;
  end
  // Device driver wins; then outside driver; then pull-up or noise
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & (pull_on | noise));
endmodule : pin_partner

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the shared I/O port
// Assumes: Partner model on the pins
// Notes:   Seeded random with corner cases
module tb_top
  import port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, arst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic        hw_standby = 1'b0, sw_standby = 1'b0, bus_doe = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, bus_dout = 8'h00, ext_val = 8'ha5, ext_oe = 8'hff;
  logic [7:0]  dir, lat, pul, ev, eo;
  logic [2:0]  op_mode = MODE_SINGLE_CHIP;
  wire logic [7:0] reg_rdata, bus_din, io_pin_in, io_pin_out, io_pin_oe, pullup_en;
  int          errors = 0, samples_checked = 0;
  always #50 clk = ~clk;
  data_bus_shared_io_port u_dut (.*);
  pin_partner u_pins (.clk(clk), .pin_out(io_pin_out), .pin_oe(io_pin_oe), .pull_on(pullup_en),
                      .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(io_pin_in));
  // Masked compare; unknown bits never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    samples_checked++;
    if (((got ^ exp) & msk) !== 8'h00) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp, msk);
  endtask : rd
  function automatic logic [7:0] level(input logic [7:0] d, input logic [7:0] l, input logic [7:0] p);
    return (d & l) | (~d & p);
  endfunction : level
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(32'h1749));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(OUTPUT_LATCH_OFS, 8'h00, 8'hff);
    rd(PULLUP_SELECT_OFS, 8'h00, 8'hff);
    rd(PIN_DIRECTION_OFS, DIRECTION_READ, 8'hff);
    rd(PIN_LEVEL_OFS, 8'ha5, 8'hff);
    rd(16'h1234, UNMAPPED_READ, 8'hff);
    chk(io_pin_oe, 8'h00, 8'hff);
    // All-input and all-output first, then random setups
    for (int k = 0; k < 24; k++) begin
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      lat = 8'($urandom);
      pul = (k < 2) ? 8'hff : 8'($urandom);
      ev = 8'($urandom);
      eo = 8'($urandom) & ~dir;
      wr(PIN_DIRECTION_OFS, dir);
      ext_val <= ev;
      ext_oe <= eo;
      wr(OUTPUT_LATCH_OFS, lat);
      wr(PULLUP_SELECT_OFS, pul);
      wr(PIN_LEVEL_OFS, ~lat);
      rd(OUTPUT_LATCH_OFS, lat, 8'hff);
      rd(PULLUP_SELECT_OFS, pul, 8'hff);
      rd(PIN_LEVEL_OFS, level(dir, lat, ev | ~eo), dir | eo | pul);
      chk(io_pin_oe, dir, 8'hff);
      chk(io_pin_out, lat, 8'hff);
      chk(pullup_en, ~dir & pul, 8'hff);
    end
    // Software standby: writes dropped, readback frozen
    @(posedge clk);
    sw_standby <= 1'b1;
    wr(OUTPUT_LATCH_OFS, ~lat);
    ext_val <= ~ev;
    rd(OUTPUT_LATCH_OFS, lat, 8'hff);
    rd(PIN_LEVEL_OFS, level(dir, lat, ev | ~eo), dir | eo | pul);
    chk(pullup_en, ~dir & pul, 8'hff);
    @(posedge clk);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(pullup_en, 8'h00, 8'hff);
    @(posedge clk);
    hw_standby <= 1'b0;
    rd(OUTPUT_LATCH_OFS, 8'h00, 8'hff);
    rd(PULLUP_SELECT_OFS, 8'h00, 8'hff);
    rd(PIN_LEVEL_OFS, ~ev, eo);
    chk(io_pin_oe, 8'h00, 8'hff);
    // Mode 3 leaves pins as inputs; bus modes ignore the registers even with pull-ups selected
    wr(PULLUP_SELECT_OFS, 8'hff);
    for (int m = 3; m <= 6; m++) begin
      ev = 8'($urandom);
      @(posedge clk);
      op_mode <= 3'(m);
      bus_dout <= ev;
      bus_doe <= m[0];
      @(posedge clk);
      #1 chk(io_pin_oe, (m > 3) ? {8{m[0]}} : 8'h00, 8'hff);
      chk(io_pin_out, ev, (m > 3) ? 8'hff : 8'h00);
      chk(pullup_en, 8'h00, 8'hff);
      chk(bus_din, (m == 5) ? ev : ext_val, (m == 5) ? 8'hff : ext_oe);
    end
    @(posedge clk);
    op_mode <= MODE_SINGLE_CHIP;
    @(posedge clk);
    #1 chk(pullup_en, 8'hff, 8'hff);
    conclude();
  end
endmodule : tb_top
